// ### hw/sock_force_consts.vh
`ifndef SOCK_FORCE_CONSTS_VH
`define SOCK_FORCE_CONSTS_VH

// Register byte addresses (low 8 address bits)
`define ADDR_EVENT      8'h00
`define ADDR_PRESENT    8'h08
`define ADDR_OVERRIDE   8'h0c
`define ADDR_IRQ_STAT   8'h40
`define ADDR_IRQ_EN     8'h44
`define ADDR_IRQ_CLR    8'h48
`define ADDR_CTRL       8'h4c

// Override register fields
`define OVR_REINTERROGATE 14
`define OVR_YV            13
`define OVR_XV            12
`define OVR_3V3           11
`define OVR_5V            10
`define OVR_INVALID       9
`define OVR_LOSS          8
`define OVR_UNRECOG       7
`define OVR_CARDBUS       5
`define OVR_SIXTEEN       4
`define OVR_PWR_EVT       3
`define OVR_DET2_EVT      2
`define OVR_DET1_EVT      1
`define OVR_STS_EVT       0

// Present-state field positions
`define PS_VOLT_LO        10
`define PS_VOLT_HI        13
`define PS_SOCK_3V3       29
`define PS_SOCK_5V        28

// Event register width
`define EVT_W             4

// Interrupt status bits
`define IRQ_W             3
`define IRQ_FORCED_EVT    0
`define IRQ_REINT_DONE    1
`define IRQ_PWRCTL_OFF    2

// Control register bit
`define CTRL_PME_EN       0

// Context flag positions inside the stored context word
`define CTX_INVALID       5
`define CTX_LOSS          4
`define CTX_UNRECOG       3
`define CTX_CARDBUS       2
`define CTX_SIXTEEN       1

// AXI responses
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// ### hw/sticky_bits.v
`timescale 1ns/1ns
// Set-dominant sticky flags with a per-bit clear
module sticky_bits #(
   parameter W = 4
) (
   input  wire         clk_sys_i,
   input  wire         rst_n_i,
   input  wire         ce_i,
   input  wire [W-1:0] set_i,
   input  wire [W-1:0] clr_i,
   input  wire [W-1:0] wr_i,
   input  wire [W-1:0] wdata_i,
   output wire [W-1:0] flags_o
);
   reg [W-1:0] flags_q;
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : gen_bit
         // Hardware set wins over any clear or write of zero
         always @(posedge clk_sys_i) begin
            if (!rst_n_i) begin
               flags_q[g] <= 1'b0;
            end else if (ce_i) begin
               if (set_i[g]) begin
                  flags_q[g] <= 1'b1;
               end else if (wr_i[g]) begin
                  flags_q[g] <= wdata_i[g];
               end else if (clr_i[g]) begin
                  flags_q[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate
   assign flags_o = flags_q;
endmodule // sticky_bits

// ### hw/axil_slave_port.v
`timescale 1ns/1ns
`include "sock_force_consts.vh"
// AXI4-Lite slave front end: one write and one read at a time
module axil_slave_port (
   input  wire        clk_sys_i,
   input  wire        rst_n_i,
   input  wire        ce_i,
   input  wire [7:0]  s_axi_awaddr_i,
   input  wire        s_axi_awvalid_i,
   output wire        s_axi_awready_o,
   input  wire [31:0] s_axi_wdata_i,
   input  wire [3:0]  s_axi_wstrb_i,
   input  wire        s_axi_wvalid_i,
   output wire        s_axi_wready_o,
   output reg  [1:0]  s_axi_bresp_o,
   output reg         s_axi_bvalid_o,
   input  wire        s_axi_bready_i,
   input  wire [7:0]  s_axi_araddr_i,
   input  wire        s_axi_arvalid_i,
   output wire        s_axi_arready_o,
   output reg  [31:0] s_axi_rdata_o,
   output reg  [1:0]  s_axi_rresp_o,
   output reg         s_axi_rvalid_o,
   input  wire        s_axi_rready_i,
   output wire        wr_en_o,
   output wire [7:0]  wr_addr_o,
   output wire [31:0] wr_data_o,
   output wire [3:0]  wr_strb_o,
   input  wire        wr_ok_i,
   output wire        rd_en_o,
   output wire [7:0]  rd_addr_o,
   input  wire [31:0] rd_data_i,
   input  wire        rd_ok_i
);
   reg        aw_have_q;
   reg        w_have_q;
   reg [7:0]  awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0]  wstrb_q;

   // Accept channels independently, stall while a response is pending
   assign s_axi_awready_o = ce_i && !aw_have_q && !s_axi_bvalid_o;
   assign s_axi_wready_o  = ce_i && !w_have_q && !s_axi_bvalid_o;
   assign s_axi_arready_o = ce_i && !s_axi_rvalid_o;
   assign wr_en_o   = ce_i && aw_have_q && w_have_q && !s_axi_bvalid_o;
   assign wr_addr_o = awaddr_q;
   assign wr_data_o = wdata_q;
   assign wr_strb_o = wstrb_q;
   assign rd_en_o   = s_axi_arvalid_i && s_axi_arready_o;
   assign rd_addr_o = s_axi_araddr_i;

   // Write address/data capture and response
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         aw_have_q      <= 1'b0;
         w_have_q       <= 1'b0;
         awaddr_q       <= 8'h00;
         wdata_q        <= 32'h0000_0000;
         wstrb_q        <= 4'h0;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o  <= `RESP_OKAY;
      end else if (ce_i) begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_have_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_have_q <= 1'b1;
            wdata_q  <= s_axi_wdata_i;
            wstrb_q  <= s_axi_wstrb_i;
         end
         if (wr_en_o) begin
            aw_have_q      <= 1'b0;
            w_have_q       <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_ok_i ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
         end
      end
   end

   // Read data, one cycle after address is taken
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o  <= 32'h0000_0000;
         s_axi_rresp_o  <= `RESP_OKAY;
      end else if (ce_i) begin
         if (rd_en_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= rd_ok_i ? rd_data_i : 32'h0000_0000;
            s_axi_rresp_o  <= rd_ok_i ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
         end
      end
   end
endmodule // axil_slave_port

// ### hw/socket_force_event_logic.v
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "sock_force_consts.vh"

module socket_force_event_logic #(
   parameter SOCK_3V3_CAP = 1'b1,
   parameter SOCK_5V_CAP  = 1'b1
) (
   input  wire        clk_sys_i,
   input  wire        rst_n_i,
   input  wire        global_reset_n_i,
   input  wire        ce_i,
   input  wire [7:0]  s_axi_awaddr_i,
   input  wire        s_axi_awvalid_i,
   output wire        s_axi_awready_o,
   input  wire [31:0] s_axi_wdata_i,
   input  wire [3:0]  s_axi_wstrb_i,
   input  wire        s_axi_wvalid_i,
   output wire        s_axi_wready_o,
   output wire [1:0]  s_axi_bresp_o,
   output wire        s_axi_bvalid_o,
   input  wire        s_axi_bready_i,
   input  wire [7:0]  s_axi_araddr_i,
   input  wire        s_axi_arvalid_i,
   output wire        s_axi_arready_o,
   output wire [31:0] s_axi_rdata_o,
   output wire [1:0]  s_axi_rresp_o,
   output wire        s_axi_rvalid_o,
   input  wire        s_axi_rready_i,
   input  wire [3:0]  card_volt_report_i,
   input  wire        reint_done_i,
   input  wire [5:0]  reint_flags_i,
   input  wire        socket_powered_i,
   input  wire        detect_two_status_i,
   input  wire        detect_one_status_i,
   input  wire        status_change_level_i,
   input  wire        irq_ready_level_i,
   input  wire [3:0]  event_set_i,
   output wire        reint_start_o,
   output reg         power_ctl_enable_o,
   output wire [3:0]  event_flags_o,
   output wire        irq_o
);
   // Strobes and data handed over by the bus front end
   wire        wr_en;
   wire [7:0]  wr_addr;
   wire [31:0] wr_data;
   wire [3:0]  wr_strb;
   wire        rd_en;
   wire [7:0]  rd_addr;
   reg  [31:0] rd_data;
   reg         rd_ok;
   reg         wr_ok;

   // Stored flag state
   reg  [3:0]  volt_force_q;   // forced voltage-support flags
   reg  [5:0]  ctx_q;          // {invalid, loss, unrecog, cardbus, sixteen, rsv}
   reg         pme_en_q;
   reg         reint_q;

   // Decode a write whose address hits one register; byte strobes are checked by the caller
   function wr_hit;
      input [7:0] a;
      input [7:0] target;
      begin
         wr_hit = (a == target);
      end
   endfunction

   // True for every address that holds a register
   function is_mapped;
      input [7:0] a;
      begin
         case (a)
            `ADDR_EVENT, `ADDR_PRESENT, `ADDR_OVERRIDE, `ADDR_IRQ_STAT,
            `ADDR_IRQ_EN, `ADDR_IRQ_CLR, `ADDR_CTRL: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
         endcase
      end
   endfunction

   // Bus front end: one write and one read outstanding at most
   axil_slave_port u_bus (
      .clk_sys_i       (clk_sys_i),
      .rst_n_i         (rst_n_i),
      .ce_i            (ce_i),
      .s_axi_awaddr_i  (s_axi_awaddr_i),
      .s_axi_awvalid_i (s_axi_awvalid_i),
      .s_axi_awready_o (s_axi_awready_o),
      .s_axi_wdata_i   (s_axi_wdata_i),
      .s_axi_wstrb_i   (s_axi_wstrb_i),
      .s_axi_wvalid_i  (s_axi_wvalid_i),
      .s_axi_wready_o  (s_axi_wready_o),
      .s_axi_bresp_o   (s_axi_bresp_o),
      .s_axi_bvalid_o  (s_axi_bvalid_o),
      .s_axi_bready_i  (s_axi_bready_i),
      .s_axi_araddr_i  (s_axi_araddr_i),
      .s_axi_arvalid_i (s_axi_arvalid_i),
      .s_axi_arready_o (s_axi_arready_o),
      .s_axi_rdata_o   (s_axi_rdata_o),
      .s_axi_rresp_o   (s_axi_rresp_o),
      .s_axi_rvalid_o  (s_axi_rvalid_o),
      .s_axi_rready_i  (s_axi_rready_i),
      .wr_en_o         (wr_en),
      .wr_addr_o       (wr_addr),
      .wr_data_o       (wr_data),
      .wr_strb_o       (wr_strb),
      .wr_ok_i         (wr_ok),
      .rd_en_o         (rd_en),
      .rd_addr_o       (rd_addr),
      .rd_data_i       (rd_data),
      .rd_ok_i         (rd_ok)
   );

   // Override-register write strobes per byte lane
   // A voltage force only counts when its byte lane is written
   wire ovr_wr  = wr_en && wr_hit(wr_addr, `ADDR_OVERRIDE);
   wire ovr_lo  = ovr_wr && wr_strb[0];
   wire ovr_hi  = ovr_wr && wr_strb[1];
   wire reint_w = ovr_hi && wr_data[`OVR_REINTERROGATE];
   wire volt_w1 = ovr_hi && (|wr_data[`OVR_YV:`OVR_5V]);

   // Reinterrogation request pulse, one cycle
   // The interrogation engine sees one request per write of bit 14
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         reint_q <= 1'b0;
      end else if (ce_i) begin
         reint_q <= reint_w;
      end
   end
   assign reint_start_o = reint_q;

   // Next automatic power-control state; re-enable beats a forced disable
   reg         power_ctl_d;
   always @* begin
      power_ctl_d = power_ctl_enable_o;
      if (reint_w || reint_done_i) begin
         power_ctl_d = 1'b1;
      end else if (volt_w1) begin
         power_ctl_d = 1'b0;
      end
   end

   // Automatic power control enable, on after bus reset
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         power_ctl_enable_o <= 1'b1;
      end else if (ce_i) begin
         power_ctl_enable_o <= power_ctl_d;
      end
   end

   // Context flags: bus reset ignored while PME is enabled
   wire ctx_rst = !global_reset_n_i || (!rst_n_i && !pme_en_q);

   // Next context state; a register write beats a finishing interrogation
   reg  [3:0]  volt_force_d;
   reg  [5:0]  ctx_d;
   always @* begin
      volt_force_d = volt_force_q;
      ctx_d        = ctx_q;
      if (reint_done_i) begin
         volt_force_d = 4'h0;
         ctx_d        = reint_flags_i;
      end
      // Bits 15..8 ride on byte lane 1, bits 7..0 on lane 0
      if (ovr_hi) begin
         volt_force_d        = wr_data[`OVR_YV:`OVR_5V];
         ctx_d[`CTX_INVALID] = wr_data[`OVR_INVALID];
         ctx_d[`CTX_LOSS]    = wr_data[`OVR_LOSS];
      end
      if (ovr_lo) begin
         ctx_d[`CTX_UNRECOG] = wr_data[`OVR_UNRECOG];
         ctx_d[`CTX_CARDBUS] = wr_data[`OVR_CARDBUS];
         ctx_d[`CTX_SIXTEEN] = wr_data[`OVR_SIXTEEN];
      end
   end

   // Context and forced-voltage flags
   always @(posedge clk_sys_i) begin
      if (ctx_rst) begin
         volt_force_q <= 4'h0;
         ctx_q        <= 6'h00;
      end else if (ce_i) begin
         volt_force_q <= volt_force_d;
         ctx_q        <= ctx_d;
      end
   end

   // PME enable control bit, held by global reset only
   // It outlives a bus reset, so context flags can survive one too
   always @(posedge clk_sys_i) begin
      if (!global_reset_n_i) begin
         pme_en_q <= 1'b0;
      end else if (ce_i && wr_en && wr_hit(wr_addr, `ADDR_CTRL) &&
                   wr_strb[0]) begin
         pme_en_q <= wr_data[`CTRL_PME_EN];
      end
   end

   // Event register writes: live status inputs are never touched
   // A hardware event in the write cycle beats a forced zero
   wire [3:0] evt_wr = {4{ovr_lo}};
   sticky_bits #(
      .W (`EVT_W)
   ) u_events (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .ce_i      (ce_i),
      .set_i     (event_set_i),
      .clr_i     (4'h0),
      .wr_i      (evt_wr),
      .wdata_i   (wr_data[`OVR_PWR_EVT:`OVR_STS_EVT]),
      .flags_o   (event_flags_o)
   );

   // Interrupt sources
   // Forced events, finished scans and lost power control each set a bit
   wire [2:0] irq_set;
   wire [2:0] irq_stat;
   reg  [2:0] irq_en_q;
   wire       irq_clr_w = wr_en && wr_hit(wr_addr, `ADDR_IRQ_CLR) &&
                          wr_strb[0];
   assign irq_set[`IRQ_FORCED_EVT] = ovr_lo &&
                                     (|wr_data[`OVR_PWR_EVT:`OVR_STS_EVT]);
   assign irq_set[`IRQ_REINT_DONE] = ce_i && reint_done_i;
   assign irq_set[`IRQ_PWRCTL_OFF] = volt_w1 && !reint_w;
   sticky_bits #(
      .W (`IRQ_W)
   ) u_irq (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .ce_i      (ce_i),
      .set_i     (irq_set),
      .clr_i     (irq_clr_w ? wr_data[2:0] : 3'h0),
      .wr_i      (3'h0),
      .wdata_i   (3'h0),
      .flags_o   (irq_stat)
   );

   // Interrupt enable register
   // Only the low lane carries the three enable bits
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         irq_en_q <= 3'h0;
      end else if (ce_i && wr_en && wr_hit(wr_addr, `ADDR_IRQ_EN) &&
                   wr_strb[0]) begin
         irq_en_q <= wr_data[2:0];
      end
   end
   // Level interrupt while any enabled status bit stands
   assign irq_o = |(irq_stat & irq_en_q);

   // Present-state fields; voltage flags forced or card-reported
   wire [3:0]  volt_rd     = volt_force_q | card_volt_report_i;
   wire [1:0]  ps_sock_cap = {SOCK_3V3_CAP, SOCK_5V_CAP};
   wire [2:0]  ps_ctx_hi   = ctx_q[`CTX_INVALID:`CTX_UNRECOG];
   wire [1:0]  ps_ctx_lo   = ctx_q[`CTX_CARDBUS:`CTX_SIXTEEN];
   wire [3:0]  ps_live     = {socket_powered_i, detect_two_status_i,
                              detect_one_status_i, status_change_level_i};

   // Present-state image; bits 31..30 and 27..14 read as zero
   wire [31:0] present_rd  = {2'b00, ps_sock_cap, 14'h0000, volt_rd,
                              ps_ctx_hi, irq_ready_level_i, ps_ctx_lo,
                              ps_live};

   // Write legality: any mapped write address is accepted
   always @* begin
      wr_ok = is_mapped(wr_addr);
   end

   // Read multiplexer; unmapped addresses answer an error with zero data
   always @* begin
      rd_data = 32'h0000_0000;
      rd_ok   = is_mapped(rd_addr);
      case (rd_addr)
         `ADDR_EVENT:    rd_data = {28'h0000000, event_flags_o};
         `ADDR_PRESENT:  rd_data = present_rd;
         `ADDR_OVERRIDE: rd_data = 32'h0000_0000;
         `ADDR_IRQ_STAT: rd_data = {29'h00000000, irq_stat};
         `ADDR_IRQ_EN:   rd_data = {29'h00000000, irq_en_q};
         `ADDR_IRQ_CLR:  rd_data = 32'h0000_0000;
         `ADDR_CTRL:     rd_data = {31'h00000000, pme_en_q};
         default:        rd_data = 32'h0000_0000;
      endcase
   end
endmodule // socket_force_event_logic

// ### sim/sfe_chk.sv
`timescale 1ns/1ns
`include "sock_force_consts.vh"
// Port-level checks of the force register and its bus
module sfe_chk (
   input wire        clk_sys_i,
   input wire        rst_n_i,
   input wire        global_reset_n_i,
   input wire        ce_i,
   input wire [7:0]  s_axi_awaddr_i,
   input wire        s_axi_awvalid_i,
   input wire        s_axi_awready_o,
   input wire [31:0] s_axi_wdata_i,
   input wire [3:0]  s_axi_wstrb_i,
   input wire        s_axi_wvalid_i,
   input wire        s_axi_wready_o,
   input wire [1:0]  s_axi_bresp_o,
   input wire        s_axi_bvalid_o,
   input wire        s_axi_bready_i,
   input wire [7:0]  s_axi_araddr_i,
   input wire        s_axi_arvalid_i,
   input wire        s_axi_arready_o,
   input wire [31:0] s_axi_rdata_o,
   input wire        s_axi_rvalid_o,
   input wire        s_axi_rready_i,
   input wire        reint_done_i,
   input wire [3:0]  event_set_i,
   input wire        reint_start_o,
   input wire        power_ctl_enable_o,
   input wire [3:0]  event_flags_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i || !global_reset_n_i);
   reg  [7:0] ar_q;
   wire       wboth;
   wire       ovr;
   // Both write channels taken at one edge
   assign wboth = ce_i && s_axi_awvalid_i && s_axi_awready_o &&
                  s_axi_wvalid_i && s_axi_wready_o;
   assign ovr = wboth && s_axi_awaddr_i == `ADDR_OVERRIDE;
   // Address of the read in flight
   always @(posedge clk_sys_i) begin
      if (s_axi_arvalid_i && s_axi_arready_o)
         ar_q <= s_axi_araddr_i;
   end
   property p_reint;
      ovr && s_axi_wstrb_i[1] && s_axi_wdata_i[14] ##1 ce_i |=>
         reint_start_o;
   endproperty
   a_reint: assert property (p_reint) else $error("No restart pulse");
   property p_pulse;
      reint_start_o |=> !reint_start_o;
   endproperty
   a_pulse: assert property (p_pulse) else $error("Restart too long");
   property p_pwr_off;
      ovr && s_axi_wstrb_i[1] && (|s_axi_wdata_i[13:10]) &&
         !s_axi_wdata_i[14] ##1 ce_i && !reint_done_i |=>
         !power_ctl_enable_o;
   endproperty
   a_pwr_off: assert property (p_pwr_off) else $error("Power on");
   property p_pwr_on;
      ce_i && reint_done_i && !ovr |=> power_ctl_enable_o;
   endproperty
   a_pwr_on: assert property (p_pwr_on) else $error("Power off");
   property p_evt;
      ovr && s_axi_wstrb_i[0] ##1 ce_i && event_set_i == 4'h0 |=>
         event_flags_o == $past(s_axi_wdata_i[3:0], 2);
   endproperty
   a_evt: assert property (p_evt) else $error("Event");
   property p_bvalid;
      wboth ##1 ce_i |=> s_axi_bvalid_o;
   endproperty
   a_bvalid: assert property (p_bvalid) else $error("No write response");
   property p_bhold;
      s_axi_bvalid_o && !s_axi_bready_i |=>
         s_axi_bvalid_o && $stable(s_axi_bresp_o);
   endproperty
   a_bhold: assert property (p_bhold) else $error("Response dropped");
   property p_rhold;
      s_axi_rvalid_o && !s_axi_rready_i |=>
         s_axi_rvalid_o && $stable(s_axi_rdata_o);
   endproperty
   a_rhold: assert property (p_rhold) else $error("Read data dropped");
   property p_ovr_rd;
      s_axi_rvalid_o && ar_q == `ADDR_OVERRIDE |-> s_axi_rdata_o == 32'h0;
   endproperty
   a_ovr_rd: assert property (p_ovr_rd) else $error("Nonzero");
   property p_refuse;
      s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
   endproperty
   a_refuse: assert property (p_refuse) else $error("Write taken early");
endmodule // sfe_chk

bind socket_force_event_logic sfe_chk u_chk (.*);

// ### sim/testbench.sv
`timescale 1ns/1ns
`include "sock_force_consts.vh"
module testbench;
   reg        clk_sys_i, rst_n_i, global_reset_n_i, ce_i;
   reg [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
   reg [31:0] s_axi_wdata_i, rd, d;
   reg [3:0]  s_axi_wstrb_i, card_volt_report_i, event_set_i, s;
   reg        s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
   reg        s_axi_arvalid_i, s_axi_rready_i, reint_done_i, st, pwr;
   reg        socket_powered_i, detect_two_status_i, detect_one_status_i;
   reg        status_change_level_i, irq_ready_level_i;
   reg [5:0]  reint_flags_i;
   reg [1:0]  rs;
   reg [13:4] pm;
   reg [3:0]  ev;
   integer    num_errors, compares, seed, i;
   wire       s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
   wire       s_axi_arready_o, s_axi_rvalid_o, reint_start_o;
   wire       power_ctl_enable_o, irq_o;
   wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
   wire [31:0] s_axi_rdata_o;
   wire [3:0] event_flags_o;
   socket_force_event_logic u_dut (.*);
   // Free-running 25 MHz clock
   initial begin
      clk_sys_i = 1'b0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD %0t got %h want %h", $time, seen, exp);
         end
      end
   endtask
   task end_sim;
      begin
         $display("Compares %0d mismatches %0d", compares, num_errors);
         if (num_errors == 0 && compares > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   // One bus transfer, write when w is set, held until answered
   task bus(input w, input [7:0] a, input [31:0] dd, input [3:0] sb);
      integer n;
      begin
         @(posedge clk_sys_i);
         if (w) begin
            s_axi_awaddr_i <= a;
            s_axi_wdata_i <= dd;
            s_axi_wstrb_i <= sb;
            s_axi_awvalid_i <= 1'b1;
            s_axi_wvalid_i <= 1'b1;
            s_axi_bready_i <= 1'b1;
         end else begin
            s_axi_araddr_i <= a;
            s_axi_arvalid_i <= 1'b1;
            s_axi_rready_i <= 1'b1;
         end
         for (n = 0; n < 50; n = n + 1) begin
            @(posedge clk_sys_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
            if (s_axi_bvalid_o && s_axi_bready_i) begin
               rs = s_axi_bresp_o;
               st = reint_start_o;
               s_axi_bready_i <= 1'b0;
               n = 99;
            end
            if (s_axi_rvalid_o && s_axi_rready_i) begin
               rs = s_axi_rresp_o;
               rd = s_axi_rdata_o;
               s_axi_rready_i <= 1'b0;
               n = 99;
            end
         end
         if (n < 99) begin
            num_errors = num_errors + 1;
            $display("BAD %0t bus hang", $time);
         end
      end
   endtask
   // Override write applied to the expected flags
   task ovr(input [31:0] dd, input [3:0] sb);
      begin
         bus(1'b1, `ADDR_OVERRIDE, dd, sb);
         if (sb[0]) begin
            ev = dd[3:0];
            pm[7] = dd[7];
            pm[5:4] = dd[5:4];
         end
         if (sb[1]) begin
            pm[13:8] = dd[13:8];
            if (|dd[13:10]) pwr = 1'b0;
         end
      end
   endtask
   function [31:0] pexp(input x);
      pexp = {4'h3, 14'h0, pm[13:10] | card_volt_report_i, pm[9:7],
              irq_ready_level_i, pm[5:4], socket_powered_i,
              detect_two_status_i, detect_one_status_i,
              status_change_level_i};
   endfunction
   // Read present state and compare with the flag model
   task pchk;
      begin
         bus(1'b0, `ADDR_PRESENT, 32'h0, 4'h0);
         chk(rd, pexp(1'b0));
         chk(event_flags_o, ev);
         chk(power_ctl_enable_o, pwr);
      end
   endtask
   // Bounded run time
   initial begin
      #400000;
      num_errors = num_errors + 1;
      end_sim;
   end
   initial begin
      {rst_n_i, global_reset_n_i, s_axi_awvalid_i, s_axi_wvalid_i} = 4'h0;
      {s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i, reint_done_i} = 4'h0;
      {socket_powered_i, detect_two_status_i, detect_one_status_i} = 3'h0;
      {status_change_level_i, irq_ready_level_i} = 2'h0;
      {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 48'h0;
      {s_axi_wstrb_i, card_volt_report_i, event_set_i} = 12'h0;
      reint_flags_i = 6'h0;
      ce_i = 1'b1;
      seed = 32'hbcb9;
      {num_errors, compares} = 64'h0;
      {pm, ev, pwr} = 15'h1;
      repeat (6) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      global_reset_n_i <= 1'b1;
      pchk;
      for (i = 0; i < 24; i = i + 1) begin
         @(posedge clk_sys_i);
         {socket_powered_i, detect_two_status_i, detect_one_status_i,
            status_change_level_i, irq_ready_level_i,
            card_volt_report_i} <= $random(seed);
         d = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h0 : $random(seed);
         s = (i < 2) ? 4'hf : $random(seed);
         ovr(d & 32'hffffbfff, s);
         chk(rs, `RESP_OKAY);
         chk(st, 1'b0);
         pchk;
         bus(1'b0, `ADDR_OVERRIDE, 32'h0, 4'h0);
         chk(rd, 32'h0);
      end
      // Hardware event pulse sets event bits on its own
      event_set_i <= 4'h5;
      @(posedge clk_sys_i);
      event_set_i <= 4'h0;
      ev = ev | 4'h5;
      ovr(32'h2000, 4'h2);
      chk(power_ctl_enable_o, 1'b0);
      bus(1'b1, `ADDR_OVERRIDE, 32'h4000, 4'h2);
      pm[13:8] = 6'h0;
      chk(st, 1'b1);
      reint_flags_i <= $random(seed);
      reint_done_i <= 1'b1;
      @(posedge clk_sys_i);
      reint_done_i <= 1'b0;
      {pm[9:7], pm[5:4]} = reint_flags_i[5:1];
      pwr = 1'b1;
      pchk;
      bus(1'b1, `ADDR_IRQ_CLR, 32'h7, 4'h1);
      bus(1'b0, `ADDR_IRQ_STAT, 32'h0, 4'h0);
      chk(rd, 32'h0);
      bus(1'b1, `ADDR_IRQ_EN, 32'h0, 4'h1);
      ovr(32'h1, 4'h1);
      bus(1'b0, `ADDR_IRQ_STAT, 32'h0, 4'h0);
      chk(rd, 32'h1);
      chk(irq_o, 1'b0);
      bus(1'b1, `ADDR_IRQ_EN, 32'h7, 4'h1);
      chk(irq_o, 1'b1);
      bus(1'b1, `ADDR_IRQ_CLR, 32'h1, 4'h1);
      chk(irq_o, 1'b0);
      bus(1'b0, `ADDR_IRQ_CLR, 32'h0, 4'h0);
      chk(rd, 32'h0);
      bus(1'b1, 8'h80, 32'h1, 4'hf);
      chk(rs, `RESP_SLVERR);
      bus(1'b0, 8'h80, 32'h0, 4'h0);
      chk(rs, `RESP_SLVERR);
      chk(rd, 32'h0);
      bus(1'b1, `ADDR_CTRL, 32'h1, 4'h1);
      ovr(32'h2bb0, 4'h3);
      @(posedge clk_sys_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      {ev, pwr} = 5'h1;
      pchk;
      @(posedge clk_sys_i);
      global_reset_n_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      global_reset_n_i <= 1'b1;
      pm = 10'h0;
      pchk;
      end_sim;
   end
endmodule // testbench
